// ==== logic/dtp_pkg.sv ====
// Operation
// - Split mode: two independent 8-bit interval timers
// - Split clocks: low ext/T1/T4/T16, high match/T1/T16/T256
// - Mode 01 cascades into one 16-bit timer
// - Cascade: high counts low overflow, ignores select
// - Cascade: low match asserts without clearing counter
// - Cascade: both match clears both, irq, toggle
// - Pulse mode: toggle on low or high compare
// - Pulse mode: buffer loads on high compare match
// - Pulse polarity set by initial flip-flop state
// - PWM uses low channel; high stays usable
// - PWM toggles at compare and 2^n-1, clears there
// - PWM mode: buffer loads at 2^n-1 overflow
// - Toggle on selected match drives output pin
// - Second pair run read bits 4..6 undefined
// - Interval match clears counter, irq, optional toggle
// - Control 01 clears, 10 sets, 00 inverts flip-flop
// - Compare 00H matches on counter overflow
package dtp_pkg;
	typedef enum logic [1:0] {
		DTP_MODE_SPLIT,
		DTP_MODE_CASCADE,
		DTP_MODE_PULSE,
		DTP_MODE_PWM
	} dtp_mode_e;

	localparam logic [1:0] DTP_FF_INVERT = 2'h0;
	localparam logic [1:0] DTP_FF_CLEAR  = 2'h1;
	localparam logic [1:0] DTP_FF_SET    = 2'h2;
	localparam logic [7:0] DTP_CNT_RESET = 8'h00;
	localparam logic [7:0] DTP_MAX_8     = 8'hFF;
	localparam logic [7:0] DTP_MAX_7     = 8'h7F;
	localparam logic [7:0] DTP_MAX_6     = 8'h3F;
	localparam int         DTP_PRE_W     = 9;
	localparam int         DTP_SYNC_N    = 3;

	typedef struct packed {
		logic       low_run;
		logic       high_run;
		logic       prescaler_run;
		logic       dbuf_en;
		dtp_mode_e  mode;
		logic [1:0] pwm_period_select;
		logic [1:0] low_clock_select;
		logic [1:0] high_clock_select;
		logic       invert_enable;
		logic       invert_source_high;
	} dtp_cfg_s;
endpackage : dtp_pkg

// ==== logic/dtp_channel.sv ====
`timescale 1ns/1ps
// One 8-bit up-counter with comparator
module dtp_channel
	import dtp_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic       tick,
	input  wire logic       clear,
	input  wire logic [7:0] compare,
	output logic      [7:0] count_q,
	output logic            match,
	output logic            wrap
);
	assign wrap  = run && tick && (count_q == DTP_MAX_8);
	// 00H compare fires on overflow instead of equality with zero
	assign match = run && tick && ((compare == DTP_CNT_RESET) ? wrap :
	               (count_q + 8'h01 == compare));

	always_ff @(posedge clk_sys) begin
		if (rst || !run) begin
			count_q <= DTP_CNT_RESET;
		end else if (clear) begin
			count_q <= DTP_CNT_RESET;
		end else if (tick) begin
			count_q <= count_q + 8'h01;
		end
	end
endmodule : dtp_channel

// ==== logic/dtp_timer_pair.sv ====
`timescale 1ns/1ps
// Pair of 8-bit timers sharing a prescaler and one output flip-flop
module dtp_timer_pair
	import dtp_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire dtp_cfg_s   cfg,
	input  wire logic [7:0] low_compare_wdata,
	input  wire logic       low_compare_we,
	input  wire logic [7:0] high_compare_wdata,
	input  wire logic       high_compare_we,
	input  wire logic [1:0] ff_control,
	input  wire logic       ff_control_we,
	input  wire logic       external_count_pin,
	output logic            timer_output_pin,
	output logic            low_match_irq,
	output logic            high_match_irq,
	output logic [7:0]      low_count,
	output logic [7:0]      high_count,
	output logic [7:0]      pair_run_rdata
);
	logic [DTP_SYNC_N-1:0] ext_sync_q;
	logic                  ext_level_q;
	logic                  ext_tick;
	logic [DTP_PRE_W-1:0]  pre_q;
	logic [DTP_PRE_W-1:0]  pre_prev_q;
	logic                  t1;
	logic                  t4;
	logic                  t16;
	logic                  t256;
	logic [7:0]            low_cmp_q;
	logic [7:0]            low_buf_q;
	logic [7:0]            high_cmp_q;
	logic                  ff_q;
	logic                  low_tick;
	logic                  high_tick;
	logic                  low_clear;
	logic                  high_clear;
	logic                  low_match;
	logic                  high_match;
	logic                  low_wrap;
	logic                  low_raw;
	logic [7:0]            pwm_top;
	logic                  pwm_ovf;
	logic                  both_match;
	logic                  toggle;
	logic                  reload;

	// Middle and last stage agree before an edge counts; first stage feeds only the second
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ext_sync_q  <= '0;
			ext_level_q <= 1'b0;
		end else begin
			ext_sync_q <= {ext_sync_q[DTP_SYNC_N-2:0], external_count_pin};
			if (ext_sync_q[1] == ext_sync_q[2]) begin
				ext_level_q <= ext_sync_q[2];
			end
		end
	end
	assign ext_tick = (ext_sync_q[1] == ext_sync_q[2]) && ext_sync_q[2] && !ext_level_q;

	always_ff @(posedge clk_sys) begin
		if (rst || !cfg.prescaler_run) begin
			pre_q      <= '0;
			pre_prev_q <= '0;
		end else begin
			pre_q      <= pre_q + 9'h001;
			pre_prev_q <= pre_q;
		end
	end
	// Taps fire on the falling edge of the prescaler bits: one pulse per period
	assign t1   = cfg.prescaler_run && pre_prev_q[0] && !pre_q[0];
	assign t4   = cfg.prescaler_run && pre_prev_q[2] && !pre_q[2];
	assign t16  = cfg.prescaler_run && pre_prev_q[4] && !pre_q[4];
	assign t256 = cfg.prescaler_run && pre_prev_q[DTP_PRE_W-1] && !pre_q[DTP_PRE_W-1];

	always_comb begin
		case (cfg.low_clock_select)
			2'h0:    low_tick = ext_tick;
			2'h1:    low_tick = t1;
			2'h2:    low_tick = t4;
			default: low_tick = t16;
		endcase
	end

	always_comb begin
		if (cfg.mode == DTP_MODE_CASCADE) begin
			high_tick = low_wrap;
		end else begin
			case (cfg.high_clock_select)
				2'h0:    high_tick = low_match;
				2'h1:    high_tick = t1;
				2'h2:    high_tick = t16;
				default: high_tick = t256;
			endcase
		end
	end

	always_comb begin
		case (cfg.pwm_period_select)
			2'h1:    pwm_top = DTP_MAX_6;
			2'h2:    pwm_top = DTP_MAX_7;
			default: pwm_top = DTP_MAX_8;
		endcase
	end

	// In pulse mode the low counter is compared against the high compare too
	assign pwm_ovf    = cfg.low_run && low_tick && (low_count == pwm_top - 8'h01);
	// High half must already stand at its compare unless the low half wraps
	assign both_match = low_match && ((low_cmp_q == DTP_CNT_RESET) ? high_match :
	                    (high_count == high_cmp_q));
	assign low_raw    = cfg.low_run && low_tick &&
	                    (low_count + 8'h01 == high_cmp_q);

	always_comb begin
		case (cfg.mode)
			DTP_MODE_SPLIT: begin
				low_clear  = low_match;
				high_clear = high_match;
			end
			DTP_MODE_CASCADE: begin
				low_clear  = both_match;
				high_clear = both_match;
			end
			DTP_MODE_PULSE: begin
				low_clear  = low_raw;
				high_clear = high_match;
			end
			default: begin
				low_clear  = pwm_ovf;
				high_clear = high_match;
			end
		endcase
	end

	dtp_channel u_low (
		.clk_sys (clk_sys),
		.rst     (rst),
		.run     (cfg.low_run),
		.tick    (low_tick),
		.clear   (low_clear),
		.compare (low_cmp_q),
		.count_q (low_count),
		.match   (low_match),
		.wrap    (low_wrap)
	);

	dtp_channel u_high (
		.clk_sys (clk_sys),
		.rst     (rst),
		.run     (cfg.high_run),
		.tick    (high_tick),
		.clear   (high_clear),
		.compare (high_cmp_q),
		.count_q (high_count),
		.match   (high_match),
		.wrap    ()
	);

	always_comb begin
		case (cfg.mode)
			DTP_MODE_SPLIT:   toggle = cfg.invert_enable &&
			                  (cfg.invert_source_high ? high_match : low_match);
			DTP_MODE_CASCADE: toggle = cfg.invert_enable && both_match;
			DTP_MODE_PULSE:   toggle = cfg.invert_enable && (low_match || low_raw);
			default:          toggle = cfg.invert_enable && (low_match || pwm_ovf);
		endcase
	end

	assign reload = cfg.dbuf_en && (((cfg.mode == DTP_MODE_PULSE) && low_raw) ||
	                ((cfg.mode == DTP_MODE_PWM) && pwm_ovf));

	// With the buffer off a write lands in both; with it on only the buffer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			low_cmp_q <= DTP_CNT_RESET;
			low_buf_q <= DTP_CNT_RESET;
		end else begin
			if (low_compare_we) begin
				low_buf_q <= low_compare_wdata;
			end
			if (low_compare_we && !cfg.dbuf_en) begin
				low_cmp_q <= low_compare_wdata;
			end else if (reload) begin
				low_cmp_q <= low_buf_q;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			high_cmp_q <= DTP_CNT_RESET;
		end else if (high_compare_we) begin
			high_cmp_q <= high_compare_wdata;
		end
	end

	// Software write wins over a same-cycle hardware toggle; initial state sets polarity
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ff_q <= 1'b0;
		end else if (ff_control_we) begin
			case (ff_control)
				DTP_FF_CLEAR:  ff_q <= 1'b0;
				DTP_FF_SET:    ff_q <= 1'b1;
				DTP_FF_INVERT: ff_q <= !ff_q;
				default:       ff_q <= ff_q;
			endcase
		end else if (toggle) begin
			ff_q <= !ff_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			timer_output_pin <= 1'b0;
			low_match_irq    <= 1'b0;
			high_match_irq   <= 1'b0;
			pair_run_rdata   <= 8'h00;
		end else begin
			timer_output_pin <= ff_q;
			low_match_irq    <= low_match && (cfg.mode != DTP_MODE_PULSE);
			high_match_irq   <= (cfg.mode == DTP_MODE_CASCADE) ? both_match :
			                    (cfg.mode == DTP_MODE_PULSE) ? 1'b0 : high_match;
			// Bits 4..6 carry no state; zero is one legal undefined value
			pair_run_rdata   <= {cfg.dbuf_en, 3'h0, 1'b0, cfg.prescaler_run,
			                     cfg.high_run, cfg.low_run};
		end
	end
endmodule : dtp_timer_pair

// ==== sim/dtp_ext_src.sv ====
`timescale 1ns/1ps
// Count source for the external pin; stands low while disabled
module dtp_ext_src (
	input  wire logic clk_sys,
	input  wire logic en,
	output logic      external_count_pin
);
	logic [1:0] div_q;
	// Four-clock period so the three-flop synchroniser sees every edge
	always_ff @(posedge clk_sys) begin
		div_q <= en ? div_q + 2'h1 : 2'h0;
	end
	assign external_count_pin = div_q[1];
endmodule : dtp_ext_src

// ==== sim/dtp_timer_pair_sva.sv ====
`timescale 1ns/1ps
module dtp_timer_pair_chk
	import dtp_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire dtp_cfg_s   cfg,
	input wire logic [1:0] ff_control,
	input wire logic       ff_control_we,
	input wire logic       timer_output_pin,
	input wire logic       low_match_irq,
	input wire logic       high_match_irq,
	input wire logic [7:0] low_count,
	input wire logic [7:0] high_count
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_rst_out;
		$fell(rst) |-> low_count == 8'h00 && high_count == 8'h00 && !timer_output_pin;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
	property p_split_clr;
		low_match_irq && cfg.mode == DTP_MODE_SPLIT |-> low_count == 8'h00;
	endproperty
	a_split_clr: assert property (p_split_clr) else $error("low match left count");
	property p_casc_clr;
		high_match_irq && cfg.mode == DTP_MODE_CASCADE |-> low_count == 8'h00 && high_count == 8'h00;
	endproperty
	a_casc_clr: assert property (p_casc_clr) else $error("cascade match left counts");
	// A restart may count one tick on the second cycle
	property p_run_low;
		!cfg.low_run |=> low_count == 8'h00 ##1 low_count <= 8'h01;
	endproperty
	a_run_low: assert property (p_run_low) else $error("stopped low counter moved");
	property p_run_high;
		!cfg.high_run |=> high_count == 8'h00;
	endproperty
	a_run_high: assert property (p_run_high) else $error("stopped high counter moved");
	property p_ff_set;
		ff_control_we && ff_control == DTP_FF_SET |-> ##[1:2] timer_output_pin;
	endproperty
	a_ff_set: assert property (p_ff_set) else $error("flip-flop not set");
	property p_pulse_noirq;
		cfg.mode == DTP_MODE_PULSE && $stable(cfg.mode) |-> !low_match_irq && !high_match_irq;
	endproperty
	a_pulse_noirq: assert property (p_pulse_noirq) else $error("irq in pulse mode");
	property p_pwm_range;
		cfg.mode == DTP_MODE_PWM && cfg.pwm_period_select == 2'h1 && cfg.low_run
			&& $past(cfg.low_run) |-> low_count <= DTP_MAX_6;
	endproperty
	a_pwm_range: assert property (p_pwm_range) else $error("pwm count past period");
	c_casc: cover property (cfg.mode == DTP_MODE_CASCADE && high_match_irq);
	c_pwm: cover property (cfg.mode == DTP_MODE_PWM && $rose(timer_output_pin));
	c_ext: cover property (low_match_irq && cfg.low_clock_select == 2'h0);
endmodule : dtp_timer_pair_chk

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import dtp_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	dtp_cfg_s   cfg = '0;
	logic [7:0] low_compare_wdata = 8'h00;
	logic       low_compare_we = 1'b0;
	logic [7:0] high_compare_wdata = 8'h00;
	logic       high_compare_we = 1'b0;
	logic [1:0] ff_control = 2'h0;
	logic       ff_control_we = 1'b0;
	logic       ext_en = 1'b0;
	wire        external_count_pin;
	wire        timer_output_pin;
	wire        low_match_irq;
	wire        high_match_irq;
	wire  [7:0] low_count;
	wire  [7:0] high_count;
	wire  [7:0] pair_run_rdata;
	wire  [2:0] ev = {timer_output_pin, high_match_irq, low_match_irq};
	int         errors = 0;
	int         comparisons = 0;
	dtp_timer_pair dut_u (
		.clk_sys            (clk_sys),
		.rst                (rst),
		.cfg                (cfg),
		.low_compare_wdata  (low_compare_wdata),
		.low_compare_we     (low_compare_we),
		.high_compare_wdata (high_compare_wdata),
		.high_compare_we    (high_compare_we),
		.ff_control         (ff_control),
		.ff_control_we      (ff_control_we),
		.external_count_pin (external_count_pin),
		.timer_output_pin   (timer_output_pin),
		.low_match_irq      (low_match_irq),
		.high_match_irq     (high_match_irq),
		.low_count          (low_count),
		.high_count         (high_count),
		.pair_run_rdata     (pair_run_rdata)
	);
	dtp_ext_src src_u (.clk_sys(clk_sys), .en(ext_en), .external_count_pin(external_count_pin));
	initial forever #2 clk_sys = ~clk_sys;
	task conclude;
		$display("comparisons %0d, errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
		end
	endtask : chk
	// Cycles until the next rising edge of one event line
	task rise(input int i, output int n);
		logic p;
		p = ev[i];
		for (n = 1; n < 2000; n++) begin
			@(negedge clk_sys);
			if (ev[i] && !p)
				return;
			p = ev[i];
		end
		errors++;
		conclude();
	endtask : rise
	task gap(input int i, input int exp);
		int n;
		rise(i, n);
		rise(i, n);
		chk(n, exp);
	endtask : gap
	// Stop, program, then run: counters restart from zero
	task start(input dtp_mode_e m, input logic [1:0] ls, hs, input logic [7:0] lc, hc);
		@(negedge clk_sys);
		cfg.low_run = 1'b0;
		cfg.high_run = 1'b0;
		cfg.mode = m;
		cfg.low_clock_select = ls;
		cfg.high_clock_select = hs;
		low_compare_wdata = lc;
		high_compare_wdata = hc;
		low_compare_we = 1'b1;
		high_compare_we = 1'b1;
		@(negedge clk_sys);
		low_compare_we = 1'b0;
		high_compare_we = 1'b0;
		cfg.low_run = 1'b1;
		cfg.high_run = 1'b1;
	endtask : start
	task t_ff;
		logic [1:0] code [3] = '{DTP_FF_SET, DTP_FF_CLEAR, DTP_FF_INVERT};
		for (int k = 0; k < 3; k++) begin
			@(negedge clk_sys);
			ff_control = code[k];
			ff_control_we = 1'b1;
			@(negedge clk_sys);
			ff_control_we = 1'b0;
			repeat (2) @(negedge clk_sys);
			chk(timer_output_pin, k != 1);
		end
		$display("test flip-flop control done");
	endtask : t_ff
	task t_split;
		cfg.prescaler_run = 1'b1;
		cfg.invert_enable = 1'b1;
		cfg.invert_source_high = 1'b1;
		start(DTP_MODE_SPLIT, 2'h1, 2'h1, 8'h05, 8'h03);
		gap(0, 10);
		gap(1, 6);
		gap(2, 12);
		start(DTP_MODE_SPLIT, 2'h1, 2'h1, 8'h00, 8'h03);
		gap(0, 512);
		start(DTP_MODE_SPLIT, 2'h0, 2'h0, 8'h04, 8'h02);
		ext_en = 1'b1;
		gap(0, 16);
		gap(1, 32);
		ext_en = 1'b0;
		$display("test split done");
	endtask : t_split
	task t_casc;
		start(DTP_MODE_CASCADE, 2'h1, 2'h3, 8'h02, 8'h01);
		gap(1, 516);
		$display("test cascade done");
	endtask : t_casc
	task t_pulse;
		start(DTP_MODE_PULSE, 2'h1, 2'h0, 8'h02, 8'h06);
		gap(2, 12);
		$display("test pulse done");
	endtask : t_pulse
	task t_pwm;
		for (int s = 1; s < 4; s++) begin
			@(negedge clk_sys);
			cfg.low_run = 1'b0;
			cfg.pwm_period_select = s[1:0];
			start(DTP_MODE_PWM, 2'h1, 2'h1, 8'h10, 8'h20);
			gap(2, ((1 << (s + 5)) - 1) * 2);
			gap(1, 64);
		end
		$display("test pwm done");
	endtask : t_pwm
	// Buffered compare may only take effect after the period ends
	task t_dbuf;
		int n;
		rise(0, n);
		@(negedge clk_sys);
		cfg.dbuf_en = 1'b1;
		low_compare_wdata = 8'h20;
		low_compare_we = 1'b1;
		@(negedge clk_sys);
		low_compare_we = 1'b0;
		rise(0, n);
		// Full period plus sixteen ticks, less the two write cycles
		chk(n, 255 * 2 + 32 - 2);
		$display("test double buffer done");
	endtask : t_dbuf
	initial begin
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		chk({low_count, high_count}, 16'h0000);
		chk({timer_output_pin, pair_run_rdata[6:4]}, 4'h0);
		t_ff();
		t_split();
		t_casc();
		t_pulse();
		t_pwm();
		t_dbuf();
		conclude();
	end
endmodule : tb_top
bind dtp_timer_pair dtp_timer_pair_chk chk_u (
	.clk_sys          (clk_sys),
	.rst              (rst),
	.cfg              (cfg),
	.ff_control       (ff_control),
	.ff_control_we    (ff_control_we),
	.timer_output_pin (timer_output_pin),
	.low_match_irq    (low_match_irq),
	.high_match_irq   (high_match_irq),
	.low_count        (low_count),
	.high_count       (high_count)
);
